/* File: adcsq_consts.vh */
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH

// System clock period in ns (10 MHz)
`define ADCSQ_CLK_PERIOD_NS     100

// Result and conversion-clock counter widths
`define ADCSQ_RES_W             10
`define ADCSQ_PRESC_W           7
`define ADCSQ_CYC_W             5

// Conversion lengths in conversion clock cycles
`define ADCSQ_LEN_NORMAL        5'h0D
`define ADCSQ_LEN_FIRST         5'h19
// Cycle index whose falling half holds the sample-and-hold
`define ADCSQ_SH_NORMAL         5'h01
`define ADCSQ_SH_FIRST          5'h0D

// Successive-approximation start pattern (MSB trial)
`define ADCSQ_SAR_MSB           10'h200

// Reference select encodings
`define ADCSQ_REF_EXTERNAL      2'h0
`define ADCSQ_REF_SUPPLY        2'h1
`define ADCSQ_REF_INTERNAL      2'h3

// Channel select encodings
`define ADCSQ_CH_SE_LAST        5'h07
`define ADCSQ_CH_GAIN_A_FIRST   5'h08
`define ADCSQ_CH_GAIN_B_FIRST   5'h0B
`define ADCSQ_CH_COMMON_FIRST   5'h0E
`define ADCSQ_CH_COMMON_LAST    5'h14
`define ADCSQ_CH_BANDGAP        5'h1E
`define ADCSQ_CH_GROUND         5'h1F

// Gain encodings
`define ADCSQ_GAIN_1X           2'h0
`define ADCSQ_GAIN_10X          2'h1
`define ADCSQ_GAIN_200X         2'h2

// Analog pin numbers used by differential pairs
`define ADCSQ_PIN_0             3'h0
`define ADCSQ_PIN_1             3'h1
`define ADCSQ_PIN_2             3'h2
`define ADCSQ_PIN_3             3'h3

`endif

/* File: adcsq_presc.v */
`timescale 1ns/100ps
`include "adcsq_consts.vh"

module adcsq_presc (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       enable,
    input  wire [2:0] div_sel,
    output reg        rise_tick,
    output reg        fall_tick,
    output reg        half_clk
);

    reg  [`ADCSQ_PRESC_W-1:0] cnt_r;
    wire [`ADCSQ_PRESC_W-1:0] mask;
    wire [`ADCSQ_PRESC_W-1:0] cnt_nxt;

    // Divide by 2^sel, with select zero also dividing by two
    function [`ADCSQ_PRESC_W-1:0] div_mask;
        input [2:0] sel;
        reg   [2:0] k;
        begin
            k = (sel == 3'h0) ? 3'h1 : sel;
            div_mask = (7'h01 << k) - 7'h01;
        end
    endfunction

    assign mask    = div_mask(div_sel);
    assign cnt_nxt = cnt_r + 7'h01;

    always @* begin
        rise_tick = enable && ((cnt_r & mask) == mask);
        fall_tick = enable && ((cnt_r & mask) == (mask >> 1));
    end

    // Counter is held at zero whenever the converter is off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= 7'h00;
            half_clk <= 1'b0;
        end else if (!enable) begin
            cnt_r    <= 7'h00;
            half_clk <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            if (rise_tick) begin
                half_clk <= ~half_clk;
            end
        end
    end

endmodule

/* File: adcsq_top.v */
`timescale 1ns/100ps
`include "adcsq_consts.vh"

module adcsq_top (
    input  wire       CLK,
    input  wire       RST_N,
    input  wire       CONVERTER_ENABLE,
    input  wire       CONVERSION_START_WR,
    input  wire       FREE_RUN_SELECT,
    input  wire       CONVERSION_INTERRUPT_ENABLE,
    input  wire       DONE_FLAG_CLEAR,
    input  wire       INT_VECTOR_ACK,
    input  wire       LEFT_ADJUST_SELECT,
    input  wire [2:0] CLOCK_DIVIDER_SELECT,
    input  wire [1:0] REFERENCE_SELECT,
    input  wire [4:0] INPUT_CHANNEL_SELECT,
    input  wire       RESULT_LOW_READ,
    input  wire       RESULT_HIGH_READ,
    input  wire       COMPARATOR_HIGH,
    output reg        ANALOG_POWER_ON,
    output reg        REF_SUPPLY_ON,
    output reg        REF_INTERNAL_ON,
    output reg  [2:0] POS_INPUT_SEL,
    output reg  [2:0] NEG_INPUT_SEL,
    output reg  [1:0] GAIN_SEL,
    output reg        GAIN_BYPASS,
    output reg        SELECT_BANDGAP,
    output reg        SELECT_GROUND,
    output reg  [9:0] SAR_DAC_CODE,
    output reg        SAMPLE_HOLD,
    output wire       CONVERSION_START_BIT,
    output wire       CONVERSION_DONE_FLAG,
    output wire       CONVERTING,
    output wire       IRQ,
    output reg  [7:0] RESULT_LOW_BYTE,
    output reg  [7:0] RESULT_HIGH_BYTE
);

    wire        rise_tick;
    wire        fall_tick;
    wire        half_clk;

    reg         start_r;
    reg         busy_r;
    reg         first_r;
    reg         extra_r;
    reg         diff_r;
    reg         done_r;
    reg         lock_r;
    reg  [4:0]  cyc_r;
    reg  [9:0]  ptr_r;
    reg  [9:0]  res_r;
    reg  [1:0]  ref_app_r;
    reg  [10:0] chan_app_r;

    wire [10:0] chan_dec;
    wire        begin_conv;
    wire        last_cyc;
    wire        complete;
    wire        restart;
    wire [4:0]  len;
    wire [4:0]  sh_cyc;
    wire [9:0]  trial;
    wire [4:0]  cyc_nxt;

    adcsq_presc u_presc (
        .clk       (CLK),
        .rst_n     (RST_N),
        .enable    (CONVERTER_ENABLE),
        .div_sel   (CLOCK_DIVIDER_SELECT),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick),
        .half_clk  (half_clk)
    );

    // Packed: {diff, pos[2:0], neg[2:0], gain[1:0], bandgap, ground}
    function [10:0] chan_decode;
        input [4:0] ch;
        reg   [4:0] off;
        begin
            chan_decode = {1'b0, 3'h0, 3'h0, `ADCSQ_GAIN_1X, 1'b0, 1'b1};
            if (ch <= `ADCSQ_CH_SE_LAST) begin
                chan_decode = {1'b0, ch[2:0], 3'h0,
                               `ADCSQ_GAIN_1X, 1'b0, 1'b0};
            end else if (ch < `ADCSQ_CH_GAIN_B_FIRST) begin
                off = ch - `ADCSQ_CH_GAIN_A_FIRST;
                chan_decode = {1'b1, `ADCSQ_PIN_1, `ADCSQ_PIN_0,
                               off[1:0], 1'b0, 1'b0};
            end else if (ch < `ADCSQ_CH_COMMON_FIRST) begin
                off = ch - `ADCSQ_CH_GAIN_B_FIRST;
                chan_decode = {1'b1, `ADCSQ_PIN_3, `ADCSQ_PIN_2,
                               off[1:0], 1'b0, 1'b0};
            end else if (ch <= `ADCSQ_CH_COMMON_LAST) begin
                off = ch - `ADCSQ_CH_COMMON_FIRST;
                // Positive walks pins 0,2..7 skipping the common pin
                if (off != 5'h00) begin
                    off = off + 5'h01;
                end
                chan_decode = {1'b1, off[2:0], `ADCSQ_PIN_1,
                               `ADCSQ_GAIN_1X, 1'b0, 1'b0};
            end else if (ch == `ADCSQ_CH_BANDGAP) begin
                chan_decode = {1'b0, 3'h0, 3'h0,
                               `ADCSQ_GAIN_1X, 1'b1, 1'b0};
            end
        end
    endfunction

    function [7:0] align_byte;
        input [9:0] r;
        input       left;
        input       high;
        begin
            if (left) begin
                align_byte = high ? r[9:2] : {r[1:0], 6'h00};
            end else begin
                align_byte = high ? {6'h00, r[9:8]} : r[7:0];
            end
        end
    endfunction

    assign chan_dec   = chan_decode(INPUT_CHANNEL_SELECT);
    assign begin_conv = start_r && !busy_r && rise_tick;
    assign len        = first_r ? `ADCSQ_LEN_FIRST :
                        (`ADCSQ_LEN_NORMAL + {4'h0, extra_r});
    assign sh_cyc     = first_r ? `ADCSQ_SH_FIRST :
                        (`ADCSQ_SH_NORMAL + {4'h0, extra_r});
    assign last_cyc   = (cyc_r == (len - 5'h01));
    assign complete   = busy_r && rise_tick && last_cyc;
    assign restart    = complete && FREE_RUN_SELECT;
    assign cyc_nxt    = cyc_r + 5'h01;
    assign trial      = COMPARATOR_HIGH ? SAR_DAC_CODE
                                        : (SAR_DAC_CODE & ~ptr_r);

    assign CONVERSION_START_BIT = start_r;
    assign CONVERSION_DONE_FLAG = done_r;
    assign CONVERTING           = busy_r;
    assign IRQ = done_r && CONVERSION_INTERRUPT_ENABLE;

    // Conversion sequencer
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            start_r      <= 1'b0;
            busy_r       <= 1'b0;
            first_r      <= 1'b1;
            extra_r      <= 1'b0;
            cyc_r        <= 5'h00;
            ptr_r        <= 10'h000;
            SAR_DAC_CODE <= 10'h000;
            SAMPLE_HOLD  <= 1'b0;
        end else if (!CONVERTER_ENABLE) begin
            // Switching off aborts and rearms the long first conversion
            start_r      <= 1'b0;
            busy_r       <= 1'b0;
            first_r      <= 1'b1;
            extra_r      <= 1'b0;
            cyc_r        <= 5'h00;
            ptr_r        <= 10'h000;
            SAMPLE_HOLD  <= 1'b0;
        end else begin
            SAMPLE_HOLD <= busy_r && fall_tick && (cyc_r == sh_cyc);
            if (busy_r && fall_tick && (cyc_r == sh_cyc)) begin
                ptr_r        <= `ADCSQ_SAR_MSB;
                SAR_DAC_CODE <= `ADCSQ_SAR_MSB;
            end else if (busy_r && rise_tick && (ptr_r != 10'h000)) begin
                ptr_r        <= ptr_r >> 1;
                SAR_DAC_CODE <= trial | (ptr_r >> 1);
            end
            if (CONVERSION_START_WR) begin
                start_r <= 1'b1;
            end else if (complete && !FREE_RUN_SELECT) begin
                start_r <= 1'b0;
            end
            if (begin_conv) begin
                busy_r  <= 1'b1;
                cyc_r   <= 5'h00;
                // Sync delay only when the half clock is high at start
                extra_r <= chan_app_r[10] && half_clk;
            end else if (restart) begin
                cyc_r   <= 5'h00;
                first_r <= 1'b0;
                extra_r <= chan_app_r[10];
            end else if (complete) begin
                busy_r  <= 1'b0;
                first_r <= 1'b0;
                extra_r <= 1'b0;
            end else if (busy_r && rise_tick) begin
                cyc_r <= cyc_nxt;
            end
        end
    end

    // Result capture, read lock and completion flag
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            res_r  <= 10'h000;
            lock_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (complete && !lock_r) begin
                res_r <= SAR_DAC_CODE;
            end
            if (RESULT_HIGH_READ) begin
                lock_r <= 1'b0;
            end else if (RESULT_LOW_READ) begin
                lock_r <= 1'b1;
            end
            // A completion beats a clear in the same cycle
            if (complete) begin
                done_r <= 1'b1;
            end else if (DONE_FLAG_CLEAR || INT_VECTOR_ACK) begin
                done_r <= 1'b0;
            end
        end
    end

    // Selections follow software only while enabled and not converting,
    // plus the completion cycle so a free-run restart sees the new pick
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_app_r  <= `ADCSQ_REF_EXTERNAL;
            chan_app_r <= {1'b0, 3'h0, 3'h0, `ADCSQ_GAIN_1X, 1'b0, 1'b1};
        end else if (CONVERTER_ENABLE && (!busy_r || complete)) begin
            ref_app_r  <= REFERENCE_SELECT;
            chan_app_r <= chan_dec;
        end
    end

    // Registered analog controls and aligned result bytes
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ANALOG_POWER_ON  <= 1'b0;
            REF_SUPPLY_ON    <= 1'b0;
            REF_INTERNAL_ON  <= 1'b0;
            POS_INPUT_SEL    <= 3'h0;
            NEG_INPUT_SEL    <= 3'h0;
            GAIN_SEL         <= `ADCSQ_GAIN_1X;
            GAIN_BYPASS      <= 1'b1;
            SELECT_BANDGAP   <= 1'b0;
            SELECT_GROUND    <= 1'b0;
            RESULT_LOW_BYTE  <= 8'h00;
            RESULT_HIGH_BYTE <= 8'h00;
        end else begin
            ANALOG_POWER_ON  <= CONVERTER_ENABLE;
            REF_SUPPLY_ON    <= CONVERTER_ENABLE &&
                                (ref_app_r == `ADCSQ_REF_SUPPLY);
            REF_INTERNAL_ON  <= CONVERTER_ENABLE &&
                                (ref_app_r == `ADCSQ_REF_INTERNAL);
            POS_INPUT_SEL    <= chan_app_r[9:7];
            NEG_INPUT_SEL    <= chan_app_r[6:4];
            GAIN_SEL         <= chan_app_r[3:2];
            GAIN_BYPASS      <= !chan_app_r[10];
            SELECT_BANDGAP   <= chan_app_r[1];
            SELECT_GROUND    <= chan_app_r[0];
            RESULT_LOW_BYTE  <= align_byte(res_r, LEFT_ADJUST_SELECT, 1'b0);
            RESULT_HIGH_BYTE <= align_byte(res_r, LEFT_ADJUST_SELECT, 1'b1);
        end
    end

endmodule

/* File: adcsq_analog_model.sv */
`timescale 1ns/100ps
module adcsq_analog_model (
    input  wire       clk,
    input  wire       sample_hold,
    input  wire [9:0] dac_code,
    input  wire [9:0] vin,
    output wire       cmp_high
);
    reg [9:0] held_r = 10'h000;
    always @(posedge clk) begin
        if (sample_hold)
            held_r <= vin;
    end
    // Tracks the input while sampling, so the first trial sees the new level
    assign cmp_high = ((sample_hold ? vin : held_r) >= dac_code);
endmodule

/* File: adcsq_monitor.sv */
`timescale 1ns/100ps
`include "adcsq_consts.vh"
module adcsq_monitor (
    input wire       CLK,
    input wire       RST_N,
    input wire       CONVERTER_ENABLE,
    input wire       CONVERSION_START_WR,
    input wire       CONVERSION_INTERRUPT_ENABLE,
    input wire       LEFT_ADJUST_SELECT,
    input wire       RESULT_LOW_READ,
    input wire       RESULT_HIGH_READ,
    input wire       ANALOG_POWER_ON,
    input wire       REF_SUPPLY_ON,
    input wire       REF_INTERNAL_ON,
    input wire [9:0] SAR_DAC_CODE,
    input wire       SAMPLE_HOLD,
    input wire       CONVERSION_START_BIT,
    input wire       CONVERSION_DONE_FLAG,
    input wire       CONVERTING,
    input wire       IRQ,
    input wire [7:0] RESULT_LOW_BYTE,
    input wire [7:0] RESULT_HIGH_BYTE
);
    reg [1:0] lk_r;
    // Lock age; the bytes may still settle for two clocks after the read
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            lk_r <= 2'h0;
        else if (RESULT_HIGH_READ)
            lk_r <= 2'h0;
        else if (RESULT_LOW_READ)
            lk_r <= 2'h1;
        else if (lk_r != 2'h0 && lk_r != 2'h3)
            lk_r <= lk_r + 2'h1;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    irq_gate_a: assert property (
        IRQ == (CONVERSION_DONE_FLAG && CONVERSION_INTERRUPT_ENABLE))
        else $error("irq does not follow flag and enable");
    power_follow_a: assert property ($past(RST_N) |->
        ANALOG_POWER_ON == $past(CONVERTER_ENABLE))
        else $error("analog power does not follow enable");
    ref_off_a: assert property (!CONVERTER_ENABLE [*2] |->
        !REF_SUPPLY_ON && !REF_INTERNAL_ON)
        else $error("reference switched while disabled");
    idle_off_a: assert property (!CONVERTER_ENABLE [*3] |->
        !CONVERTING && !CONVERSION_START_BIT && !SAMPLE_HOLD)
        else $error("activity while disabled");
    start_cause_a: assert property ($rose(CONVERSION_START_BIT) |->
        $past(CONVERSION_START_WR) && $past(CONVERTER_ENABLE))
        else $error("start bit rose without enabled write");
    start_done_a: assert property ($fell(CONVERSION_START_BIT) &&
        $past(CONVERTER_ENABLE) |-> CONVERSION_DONE_FLAG)
        else $error("start bit cleared without done flag");
    sample_pulse_a: assert property (SAMPLE_HOLD &&
        $past(CONVERTER_ENABLE) |-> CONVERTING && CONVERSION_START_BIT
        && SAR_DAC_CODE == `ADCSQ_SAR_MSB ##1 !SAMPLE_HOLD)
        else $error("bad sample pulse");
    lock_hold_a: assert property (lk_r == 2'h3 &&
        $stable(LEFT_ADJUST_SELECT) && $past(LEFT_ADJUST_SELECT, 2) ==
        LEFT_ADJUST_SELECT |-> $stable({RESULT_HIGH_BYTE, RESULT_LOW_BYTE}))
        else $error("result moved while locked");
    cover property ($rose(CONVERSION_DONE_FLAG) && lk_r == 2'h3);
    cover property (IRQ);
    cover property ($fell(CONVERSION_START_BIT));
endmodule

bind adcsq_top adcsq_monitor u_mon (
    .CLK(CLK), .RST_N(RST_N), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .CONVERSION_START_WR(CONVERSION_START_WR),
    .CONVERSION_INTERRUPT_ENABLE(CONVERSION_INTERRUPT_ENABLE),
    .LEFT_ADJUST_SELECT(LEFT_ADJUST_SELECT),
    .RESULT_LOW_READ(RESULT_LOW_READ), .RESULT_HIGH_READ(RESULT_HIGH_READ),
    .ANALOG_POWER_ON(ANALOG_POWER_ON), .REF_SUPPLY_ON(REF_SUPPLY_ON),
    .REF_INTERNAL_ON(REF_INTERNAL_ON), .SAR_DAC_CODE(SAR_DAC_CODE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONVERSION_START_BIT(CONVERSION_START_BIT),
    .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG), .CONVERTING(CONVERTING),
    .IRQ(IRQ), .RESULT_LOW_BYTE(RESULT_LOW_BYTE),
    .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE)
);

/* File: adcsq_tb_top.sv */
`timescale 1ns/100ps
module adcsq_tb_top;
    reg         clk, rst_n, en, st_wr, fr, ie, clr, ack, la, lrd, hrd;
    reg  [2:0]  dsel;
    reg  [1:0]  rsel;
    reg  [4:0]  ch;
    reg  [9:0]  vin, v;
    reg  [10:0] e, m;
    wire        cmp, pwr, rs_on, ri_on, byp, bg, gnd, sh, stb, dfl, cvt, irq;
    wire [2:0]  pos, neg;
    wire [1:0]  gain;
    wire [9:0]  dac;
    wire [7:0]  lo, hi;
    wire [10:0] rt;
    integer     n_fail, comparisons, i, k, w, g, since;
    assign rt = {byp, bg, gnd, gain, pos, neg};
    // Conversion-clock phase reference: clocks since the enable rose
    always @(posedge clk)
        since <= en ? since + 1 : 0;
    adcsq_top DUT (
        .CLK(clk), .RST_N(rst_n), .CONVERTER_ENABLE(en),
        .CONVERSION_START_WR(st_wr), .FREE_RUN_SELECT(fr),
        .CONVERSION_INTERRUPT_ENABLE(ie), .DONE_FLAG_CLEAR(clr),
        .INT_VECTOR_ACK(ack), .LEFT_ADJUST_SELECT(la),
        .CLOCK_DIVIDER_SELECT(dsel), .REFERENCE_SELECT(rsel),
        .INPUT_CHANNEL_SELECT(ch), .RESULT_LOW_READ(lrd),
        .RESULT_HIGH_READ(hrd), .COMPARATOR_HIGH(cmp),
        .ANALOG_POWER_ON(pwr), .REF_SUPPLY_ON(rs_on),
        .REF_INTERNAL_ON(ri_on), .POS_INPUT_SEL(pos), .NEG_INPUT_SEL(neg),
        .GAIN_SEL(gain), .GAIN_BYPASS(byp), .SELECT_BANDGAP(bg),
        .SELECT_GROUND(gnd), .SAR_DAC_CODE(dac), .SAMPLE_HOLD(sh),
        .CONVERSION_START_BIT(stb), .CONVERSION_DONE_FLAG(dfl),
        .CONVERTING(cvt), .IRQ(irq), .RESULT_LOW_BYTE(lo),
        .RESULT_HIGH_BYTE(hi)
    );
    adcsq_analog_model u_ana (
        .clk(clk), .sample_hold(sh), .dac_code(dac), .vin(vin),
        .cmp_high(cmp)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] x, input logic [15:0] y);
        comparisons++;
        if (y !== x) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, x, y);
        end
    endtask
    task summarize;
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function [15:0] align(input [9:0] x, input l);
        align = l ? {x, 6'h00} : {6'h00, x};
    endfunction
    // Fields: bypass, bandgap, ground, gain, positive, negative
    function [10:0] route(input [4:0] c);
        reg [4:0] d;
        d = c - 5'h0E;
        if (c <= 5'h07)
            route = {3'h4, 2'h0, c[2:0], 3'h0};
        else if (c <= 5'h0A)
            route = {3'h0, c[1:0], 3'h1, 3'h0};
        else if (c <= 5'h0D)
            route = {3'h0, c[1:0] + 2'h1, 3'h3, 3'h2};
        else if (c <= 5'h14)
            route = {5'h00, (d == 5'h00) ? 3'h0 : d[2:0] + 3'h1, 3'h1};
        else
            route = (c == 5'h1E) ? 11'h600 : 11'h500;
    endfunction
    task wait_flag;
        for (w = 0; w < 4000 && dfl !== 1'b1; w++)
            tick;
        chk("flag", 16'h1, {15'h0, dfl});
        chk("irq", {15'h0, ie}, {15'h0, irq});
    endtask
    task next_sh(output integer n);
        n = 1;
        tick;
        while (sh !== 1'b1 && n < 3000) begin
            tick;
            n++;
        end
    endtask
    task conv(input [4:0] c, input [9:0] x, input l);
        ch = c;
        vin = x;
        la = l;
        ie = 1'($urandom);
        tick;
        tick;
        st_wr = 1'b1;
        tick;
        st_wr = 1'b0;
        chk("start_bit", 16'h1, {15'h0, stb});
        wait_flag;
        chk("start_clr", 16'h0, {15'h0, stb});
        if ($urandom % 2)
            clr = 1'b1;
        else
            ack = 1'b1;
        tick;
        {clr, ack} = 2'h0;
        chk("flag_clr", 16'h0, {15'h0, dfl});
    endtask
    initial begin
        {rst_n, en, st_wr, fr, ie, clr, ack, la, lrd, hrd} = 10'h000;
        {dsel, rsel, ch, vin} = 20'h00000;
        n_fail = 0;
        comparisons = 0;
        k = $urandom(32'hDFBDA44C);
        repeat (10) @(posedge clk);
        chk("reset", 16'h10, {11'h0, byp, dfl, stb, cvt, irq});
        #1;
        rst_n = 1'b1;
        en = 1'b1;
        for (i = 0; i < 32; i++) begin
            ch = 5'(i);
            rsel = 2'($urandom);
            repeat (3) tick;
            e = route(ch);
            m = !e[10] ? 11'h7FF : ((ch <= 5'h07) ? 11'h738 : 11'h700);
            chk("route", {5'h0, e & m}, {5'h0, m & rt});
            chk("ref", {14'h0, rsel == 2'h1, rsel == 2'h3},
                {14'h0, rs_on, ri_on});
        end
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 10'h3FF : ((i == 1) ? 10'h000 : 10'($urandom));
            k = $urandom % 2;
            conv(5'($urandom % 8), v, k[0]);
            tick;
            chk("result", align(v, k[0]), {hi, lo});
        end
        v = 10'($urandom);
        conv(5'h03, v, 1'b0);
        lrd = 1'b1;
        tick;
        lrd = 1'b0;
        conv(5'h03, ~v, 1'b0);
        tick;
        chk("locked", align(v, 1'b0), {hi, lo});
        hrd = 1'b1;
        tick;
        hrd = 1'b0;
        conv(5'h03, ~v, 1'b1);
        tick;
        chk("unlocked", align(~v, 1'b1), {hi, lo});
        for (k = 0; k < 2; k++) begin
            en = 1'b0;
            dsel = 3'($urandom % 6);
            tick;
            tick;
            {en, fr} = 2'h3;
            ch = k ? 5'(8 + $urandom % 13) : 5'($urandom % 8);
            tick;
            tick;
            st_wr = 1'b1;
            tick;
            st_wr = 1'b0;
            next_sh(g);
            next_sh(g);
            w = (13 + k) * ((dsel == 3'h0) ? 2 : (1 << dsel));
            chk("gap_first", 16'(w), 16'(g));
            next_sh(g);
            chk("gap_run", 16'(w), 16'(g));
            chk("fr_start", 16'h1, {15'h0, stb});
            {en, fr, clr} = 3'h1;
            tick;
            clr = 1'b0;
        end
        // Full-resolution clock; user starts land on either half-rate phase
        dsel = 3'h6 + 3'($urandom % 2);
        en = 1'b1;
        conv(5'h08 + 5'($urandom % 13), 10'($urandom), 1'b0);
        for (i = 0; i < 4; i++) begin
            repeat ($urandom % 256) tick;
            st_wr = 1'b1;
            tick;
            st_wr = 1'b0;
            for (g = 0; g < 300 && cvt !== 1'b1; g++)
                tick;
            w = ((since >> dsel) % 2 == 0) ? 14 : 13;
            e = route(ch);
            ch = 5'h0E + 5'(i);
            for (g = 0; g < 4000 && cvt === 1'b1; g++)
                tick;
            chk("diff_len", 16'(w << dsel), 16'(g));
            chk("old_chan", {5'h0, e}, {5'h0, rt});
            tick;
            e = route(ch);
            chk("new_chan", {5'h0, e}, {5'h0, rt});
        end
        summarize;
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        summarize;
    end
endmodule
